//--- logic/ssaseq_conv_timer.sv
`default_nettype none
// times one channel conversion from the system clock or the external clock
module ssaseq_conv_timer (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic use_ext_in,
  input wire logic ext_clk_in,
  output logic done_out
);
  import ssaseq_pkg::*;

  logic running_reg, running_next;
  logic ext_mode_reg, ext_mode_next;
  logic ext_prev_reg;
  logic done_reg, done_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic tick;
  logic [CNT_W-1:0] last;

  // source is latched at start so a mid-conversion change cannot stretch it
  always_comb begin
    tick = ext_mode_reg ? (ext_clk_in & ~ext_prev_reg) : 1'b1;
    last = ext_mode_reg ? EXT_CNT_LAST : CONV_CNT_LAST;
    running_next = running_reg;
    ext_mode_next = ext_mode_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (start_in) begin
      running_next = 1'b1;
      ext_mode_next = use_ext_in;
      cnt_next = 9'h000;
    end else if (running_reg && tick) begin
      if (cnt_reg == last) begin
        running_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 9'h001;
      end
    end
  end

  // timer state
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      running_reg <= 1'b0;
      ext_mode_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= 9'h000;
    end else begin
      running_reg <= running_next;
      ext_mode_reg <= ext_mode_next;
      ext_prev_reg <= ext_clk_in;
      done_reg <= done_next;
      cnt_reg <= cnt_next;
    end
  end

  assign done_out = done_reg;
endmodule
`default_nettype wire

//--- logic/ssaseq_pkg.sv
// Behaviour
// - trigger rise holds all four, starts sequence
// - select source 0 uses pins, 1 mask
// - host write on data lines loads mask
// - selection latched at trigger rise only
// - busy high for sequence, tracking afterwards
// - internal timing unless clock source high
// - done output marks each channel conversion
// - results read over 12-bit bus
// - each selected channel takes 1.65 us on internal timing
// - unselected channels are skipped entirely
// - selected channels convert in ascending order
// - mask bit 0 is channel 1
// - single low pulse per conversion end
`default_nettype none
package ssaseq_pkg;
  localparam int NUM_CH = 4;
  localparam int DATA_W = 12;
  localparam int IDX_W = 2;
  localparam int CNT_W = 9;
  localparam int ADDR_W = 4;
  localparam int REG_W = 32;

  // timing, figures in their own units, counts derived from the clock
  localparam real CLK_PERIOD_NS = 4.0;
  localparam real CONV_TIME_US = 1.65;
  localparam real ACQ_TIME_US = 0.35;
  localparam int CONV_CYCLES =
    int'($ceil(CONV_TIME_US * 1000.0 / CLK_PERIOD_NS));
  localparam int ACQ_CYCLES =
    int'($ceil(ACQ_TIME_US * 1000.0 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] CONV_CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] ACQ_CNT_LAST = CNT_W'(ACQ_CYCLES - 1);
  // external clock edges per channel conversion
  localparam logic [CNT_W-1:0] EXT_CNT_LAST = 9'h00F;

  // register offsets
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'hC;

  // status / enable / clear bit positions
  localparam int ST_SEQ_DONE = 0;
  localparam int ST_CONV_DONE = 1;
  localparam int ST_TRIG_IGNORED = 2;
  localparam int ST_READ_IN_CONV = 3;
  localparam int ST_EARLY_TRIG = 4;
  localparam int ST_W = 5;

  // state register field positions
  localparam int SF_MASK_LSB = 0;
  localparam int SF_SEL_LSB = 4;
  localparam int SF_RPTR_LSB = 8;
  localparam int SF_BUSY = 10;
  localparam int SF_ACQ_READY = 11;
  localparam int SF_FSM_LSB = 12;

  // reset values
  localparam logic [NUM_CH-1:0] MASK_RESET = 4'hF;
  localparam logic [ST_W-1:0] ENABLE_RESET = 5'h00;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_PICK = 2'b01,
    SEQ_CONV = 2'b11
  } ssaseq_state_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } ssaseq_par_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata;
    logic wr;
    logic rd;
  } ssaseq_reg_req_t;

  typedef logic [NUM_CH-1:0][DATA_W-1:0] ssaseq_samples_t;

  // index of the lowest set bit, so channels go in ascending order
  function automatic logic [IDX_W-1:0] lowest_set(
    input logic [NUM_CH-1:0] m);
    logic [IDX_W-1:0] idx;
    idx = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction
endpackage
`default_nettype wire

//--- logic/ssaseq_result_mem.sv
`default_nettype none
// four result words; read data always come out of a register
module ssaseq_result_mem (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic wr_en_in,
  input wire logic [ssaseq_pkg::IDX_W-1:0] waddr_in,
  input wire logic [ssaseq_pkg::DATA_W-1:0] wdata_in,
  input wire logic [ssaseq_pkg::IDX_W-1:0] raddr_in,
  output logic [ssaseq_pkg::DATA_W-1:0] rdata_out
);
  import ssaseq_pkg::*;

  logic [DATA_W-1:0] mem_reg [NUM_CH];
  logic [DATA_W-1:0] rdata_reg;

  // storage has no reset, a read before the first sequence is stale
  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem_reg[waddr_in] <= wdata_in;
    end
  end

  // registered read port
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rdata_reg <= 12'h000;
    end else begin
      rdata_reg <= mem_reg[raddr_in];
    end
  end

  assign rdata_out = rdata_reg;
endmodule
`default_nettype wire

//--- logic/ssaseq_top.sv
`default_nettype none
// four-channel simultaneous sampling sequencer with parallel read port
module ssaseq_top (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic sample_trigger_in,
  input wire logic [ssaseq_pkg::NUM_CH-1:0] hw_channel_select_in,
  input wire logic select_source_in,
  input wire logic clock_source_select_in,
  input wire logic external_clock_input_in,
  input wire ssaseq_pkg::ssaseq_samples_t analog_sample_in,
  input wire ssaseq_pkg::ssaseq_par_ctrl_t par_ctrl_in,
  input wire logic [ssaseq_pkg::NUM_CH-1:0] channel_mask_lines_in,
  output logic [ssaseq_pkg::DATA_W-1:0] db_out,
  output logic db_oe_out,
  output logic busy_out,
  output logic conv_done_n_out,
  output logic [ssaseq_pkg::NUM_CH-1:0] track_hold_out,
  input wire ssaseq_pkg::ssaseq_reg_req_t reg_req_in,
  output logic [ssaseq_pkg::REG_W-1:0] reg_rdata_out,
  output logic irq_out
);
  import ssaseq_pkg::*;

  // sequencer state
  ssaseq_state_t state_reg, state_next;
  logic [NUM_CH-1:0] sel_reg, sel_next;
  logic [NUM_CH-1:0] pending_reg, pending_next;
  logic [IDX_W-1:0] ch_reg, ch_next;
  logic [IDX_W-1:0] widx_reg, widx_next;
  ssaseq_samples_t hold_reg, hold_next;
  logic busy_reg, busy_next;
  logic done_n_reg, done_n_next;
  logic trig_prev_reg;
  logic trig_rise;
  logic timer_start;
  logic timer_done;
  logic mem_wr;
  logic seq_end;

  // parallel port state
  logic [NUM_CH-1:0] mask_reg, mask_next;
  logic [NUM_CH-1:0] mask_sample_reg, mask_sample_next;
  logic wr_prev_reg, rd_prev_reg;
  logic [IDX_W-1:0] rptr_reg, rptr_next;
  logic wr_act, rd_act;
  logic [DATA_W-1:0] mem_rdata;

  // acquisition tracking
  logic acq_ready_reg, acq_ready_next;
  logic [CNT_W-1:0] acq_cnt_reg, acq_cnt_next;

  // register file
  logic [ST_W-1:0] status_reg, status_next;
  logic [ST_W-1:0] enable_reg, enable_next;
  logic [REG_W-1:0] rdata_reg, rdata_next;
  logic [ST_W-1:0] status_set;
  logic [ST_W-1:0] status_clr;

  // host strobes are active low and only count under chip select
  assign wr_act = ~par_ctrl_in.cs_n & ~par_ctrl_in.wr_n;
  assign rd_act = ~par_ctrl_in.cs_n & ~par_ctrl_in.rd_n;
  assign trig_rise = sample_trigger_in & ~trig_prev_reg;

  ssaseq_conv_timer u_timer (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .start_in(timer_start),
    .use_ext_in(clock_source_select_in),
    .ext_clk_in(external_clock_input_in),
    .done_out(timer_done)
  );

  ssaseq_result_mem u_mem (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .wr_en_in(mem_wr),
    .waddr_in(widx_reg),
    .wdata_in(hold_reg[ch_reg]),
    .raddr_in(rptr_reg),
    .rdata_out(mem_rdata)
  );

  // sequencer: trigger latches selection and samples, then one
  // conversion per selected channel, lowest channel first
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    pending_next = pending_reg;
    ch_next = ch_reg;
    widx_next = widx_reg;
    hold_next = hold_reg;
    busy_next = busy_reg;
    done_n_next = 1'b1;
    timer_start = 1'b0;
    mem_wr = 1'b0;
    seq_end = 1'b0;
    case (state_reg)
      SEQ_IDLE: begin
        // triggers while busy are ignored, the sequence is not restarted
        if (trig_rise) begin
          hold_next = analog_sample_in;
          // bit 0 of either source is channel 1
          sel_next = select_source_in ? mask_reg
                                      : hw_channel_select_in;
          pending_next = sel_next;
          widx_next = 2'h0;
          busy_next = 1'b1;
          state_next = SEQ_PICK;
        end
      end
      SEQ_PICK: begin
        if (pending_reg == 4'h0) begin
          busy_next = 1'b0;
          seq_end = 1'b1;
          state_next = SEQ_IDLE;
        end else begin
          ch_next = lowest_set(pending_reg);
          timer_start = 1'b1;
          state_next = SEQ_CONV;
        end
      end
      SEQ_CONV: begin
        if (timer_done) begin
          mem_wr = 1'b1;
          pending_next = pending_reg & ~(4'h1 << ch_reg);
          widx_next = widx_reg + 2'h1;
          done_n_next = 1'b0;
          state_next = SEQ_PICK;
        end
      end
      default: begin
        state_next = SEQ_IDLE;
        busy_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state_reg <= SEQ_IDLE;
      sel_reg <= 4'h0;
      pending_reg <= 4'h0;
      ch_reg <= 2'h0;
      widx_reg <= 2'h0;
      hold_reg <= '0;
      busy_reg <= 1'b0;
      done_n_reg <= 1'b1;
      trig_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      pending_reg <= pending_next;
      ch_reg <= ch_next;
      widx_reg <= widx_next;
      hold_reg <= hold_next;
      busy_reg <= busy_next;
      done_n_reg <= done_n_next;
      trig_prev_reg <= sample_trigger_in;
    end
  end

  // parallel port: mask is taken from the lines at the end of a write,
  // read pointer steps at the end of each read
  always_comb begin
    mask_next = mask_reg;
    mask_sample_next = mask_sample_reg;
    rptr_next = rptr_reg;
    if (wr_act) begin
      mask_sample_next = channel_mask_lines_in;
    end
    if (wr_prev_reg && !wr_act) begin
      mask_next = mask_sample_reg;
    end
    if (state_reg == SEQ_IDLE && trig_rise) begin
      rptr_next = 2'h0;
    end else if (rd_prev_reg && !rd_act) begin
      rptr_next = rptr_reg + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      mask_reg <= MASK_RESET;
      mask_sample_reg <= 4'h0;
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      rptr_reg <= 2'h0;
    end else begin
      mask_reg <= mask_next;
      mask_sample_reg <= mask_sample_next;
      wr_prev_reg <= wr_act;
      rd_prev_reg <= rd_act;
      rptr_reg <= rptr_next;
    end
  end

  // acquisition window after a sequence; only reported, since a trigger
  // that comes too early still converts, just off specification
  always_comb begin
    acq_ready_next = acq_ready_reg;
    acq_cnt_next = acq_cnt_reg;
    if (busy_reg) begin
      acq_ready_next = 1'b0;
      acq_cnt_next = 9'h000;
    end else if (!acq_ready_reg) begin
      if (acq_cnt_reg == ACQ_CNT_LAST) begin
        acq_ready_next = 1'b1;
      end else begin
        acq_cnt_next = acq_cnt_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      acq_ready_reg <= 1'b1;
      acq_cnt_reg <= 9'h000;
    end else begin
      acq_ready_reg <= acq_ready_next;
      acq_cnt_reg <= acq_cnt_next;
    end
  end

  // events into sticky status; a set in the clearing cycle wins
  always_comb begin
    status_set = '0;
    status_set[ST_SEQ_DONE] = seq_end;
    status_set[ST_CONV_DONE] = mem_wr;
    status_set[ST_TRIG_IGNORED] = trig_rise && state_reg != SEQ_IDLE;
    status_set[ST_READ_IN_CONV] = rd_act && !rd_prev_reg &&
                                  state_reg == SEQ_CONV;
    status_set[ST_EARLY_TRIG] = trig_rise && state_reg == SEQ_IDLE &&
                                !acq_ready_reg;
    status_clr = '0;
    if (reg_req_in.wr && reg_req_in.addr == REG_IRQ_CLEAR) begin
      status_clr = reg_req_in.wdata[ST_W-1:0];
    end
    status_next = (status_reg & ~status_clr) | status_set;
    enable_next = enable_reg;
    if (reg_req_in.wr && reg_req_in.addr == REG_IRQ_ENABLE) begin
      enable_next = reg_req_in.wdata[ST_W-1:0];
    end
    // read data stand only in the cycle after the strobe
    rdata_next = '0;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        REG_STATUS: rdata_next[ST_W-1:0] = status_reg;
        REG_IRQ_ENABLE: rdata_next[ST_W-1:0] = enable_reg;
        REG_STATE: begin
          rdata_next[SF_MASK_LSB +: NUM_CH] = mask_reg;
          rdata_next[SF_SEL_LSB +: NUM_CH] = sel_reg;
          rdata_next[SF_RPTR_LSB +: IDX_W] = rptr_reg;
          rdata_next[SF_BUSY] = busy_reg;
          rdata_next[SF_ACQ_READY] = acq_ready_reg;
          rdata_next[SF_FSM_LSB +: 2] = state_reg;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      status_reg <= '0;
      enable_reg <= ENABLE_RESET;
      rdata_reg <= '0;
    end else begin
      status_reg <= status_next;
      enable_reg <= enable_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs; the bus is driven only while chip select and read are low
  assign db_out = mem_rdata;
  assign db_oe_out = rd_act;
  assign busy_out = busy_reg;
  assign track_hold_out = {NUM_CH{busy_reg}};
  assign conv_done_n_out = done_n_reg;
  assign reg_rdata_out = rdata_reg;
  assign irq_out = |(status_reg & enable_reg);
endmodule
`default_nettype wire

//--- tb/ssaseq_host_model.sv
`default_nettype none
// host processor: triggers, mask writes and result reads
module ssaseq_host_model (
  input wire logic ref_clk_in,
  input wire logic [ssaseq_pkg::DATA_W-1:0] db_in,
  input wire logic db_oe_in,
  output var ssaseq_pkg::ssaseq_par_ctrl_t par_ctrl_out,
  output var logic [ssaseq_pkg::NUM_CH-1:0] mask_lines_out,
  output var logic trigger_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import ssaseq_pkg::*;
  initial begin
    par_ctrl_out = 3'b111;
    mask_lines_out = 4'h0;
    trigger_out = 1'b0;
  end

  // waiting out acquisition first keeps the sample inside spec; t_ext fires with no wait on purpose
  task automatic fire(input int wait_cyc);
    repeat (wait_cyc) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    trigger_out <= 1'b1;
    @(posedge ref_clk_in);
    trigger_out <= 1'b0;
  endtask

  // released lines show the inverse, never the stale value
  task automatic write_mask(input logic [NUM_CH-1:0] m);
    @(posedge ref_clk_in);
    par_ctrl_out <= 3'b010;
    mask_lines_out <= m;
    @(posedge ref_clk_in);
    par_ctrl_out <= 3'b111;
    mask_lines_out <= ~m;
  endtask

  // reads normally wait for idle; one test reads mid-conversion on purpose
  task automatic read_word(output logic [DATA_W-1:0] d, output logic oe);
    @(posedge ref_clk_in);
    par_ctrl_out <= 3'b001;
    #1;
    d = db_in;
    oe = db_oe_in;
    @(posedge ref_clk_in);
    par_ctrl_out <= 3'b111;
    @(posedge ref_clk_in);
  endtask
endmodule
`default_nettype wire

//--- tb/ssaseq_top_properties.sv
`default_nettype none
// watches the sequencer pins; conversion window is CONV_CYCLES with margin
module ssaseq_top_properties (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic sample_trigger_in,
  input wire logic clock_source_select_in,
  input wire ssaseq_pkg::ssaseq_par_ctrl_t par_ctrl_in,
  input wire logic db_oe_out,
  input wire logic busy_out,
  input wire logic conv_done_n_out,
  input wire logic [ssaseq_pkg::NUM_CH-1:0] track_hold_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import ssaseq_pkg::*;
  logic [9:0] gap_reg;
  logic [9:0] gap_next;

  // cycles since the sequence began or the last channel finished
  always_comb begin
    gap_next = gap_reg + 10'h001;
    if (!busy_out || !conv_done_n_out) begin
      gap_next = 10'h000;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    gap_reg <= rstn_in ? gap_next : 10'h000;
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_start;
    $rose(sample_trigger_in) && !busy_out;
  endsequence
  sequence s_held;
    busy_out && track_hold_out == 4'hF;
  endsequence
  sequence s_end_conv;
    !conv_done_n_out && !clock_source_select_in;
  endsequence

  AST_BUSY_START: assert property (s_start |=> s_held)
    else $error("busy or hold missing after trigger");
  AST_NO_SPURIOUS: assert property (
    !busy_out && !$rose(sample_trigger_in) |=> !busy_out)
    else $error("busy rose without trigger");
  AST_HOLD_EQ_BUSY: assert property (
    track_hold_out == {NUM_CH{busy_out}})
    else $error("hold state differs from busy");
  AST_DONE_PULSE: assert property (
    $fell(conv_done_n_out) |=> conv_done_n_out)
    else $error("done pulse longer than one cycle");
  AST_DONE_IN_SEQ: assert property (
    !conv_done_n_out |-> busy_out)
    else $error("done pulse outside a sequence");
  AST_BUS_RELEASE: assert property (
    db_oe_out == (!par_ctrl_in.cs_n && !par_ctrl_in.rd_n))
    else $error("data bus enable wrong");
  AST_CONV_MIN: assert property (
    s_end_conv |-> int'(gap_reg) >= CONV_CYCLES - 4)
    else $error("conversion ended too early");
  AST_CONV_MAX: assert property (
    busy_out && !clock_source_select_in |-> int'(gap_reg) <= CONV_CYCLES + 4)
    else $error("conversion ran too long");
endmodule
bind ssaseq_top ssaseq_top_properties ssaseq_top_properties_inst (
  .ref_clk_in, .rstn_in, .sample_trigger_in, .clock_source_select_in,
  .par_ctrl_in, .db_oe_out, .busy_out, .conv_done_n_out, .track_hold_out);
`default_nettype wire

//--- tb/tb_ssaseq_top.sv
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_ssaseq_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ssaseq_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sel_src = 1'b0;
  logic css = 1'b0;
  logic ext_clk = 1'b0;
  logic trig;
  logic [NUM_CH-1:0] pins = 4'h0;
  logic [NUM_CH-1:0] mask_lines;
  ssaseq_samples_t smp = {12'hD04, 12'hC03, 12'hB02, 12'hA01};
  ssaseq_par_ctrl_t par_ctrl;
  ssaseq_reg_req_t req = '0;
  logic [DATA_W-1:0] db, db_bus;
  logic db_oe, busy, done_n, irq;
  logic [NUM_CH-1:0] th;
  logic [REG_W-1:0] rdat, rdata;
  int mismatches = 0;
  int cmp_count = 0;
  int done_cnt = 0;
  int busy_cnt = 0;

  ssaseq_top ssaseq_top_inst (
    .ref_clk_in(clk), .rstn_in(rstn), .sample_trigger_in(trig),
    .hw_channel_select_in(pins), .select_source_in(sel_src),
    .clock_source_select_in(css), .external_clock_input_in(ext_clk),
    .analog_sample_in(smp), .par_ctrl_in(par_ctrl),
    .channel_mask_lines_in(mask_lines), .db_out(db), .db_oe_out(db_oe),
    .busy_out(busy), .conv_done_n_out(done_n), .track_hold_out(th),
    .reg_req_in(req), .reg_rdata_out(rdat), .irq_out(irq));
  ssaseq_host_model ssaseq_host_model_inst (
    .ref_clk_in(clk), .db_in(db_bus), .db_oe_in(db_oe),
    .par_ctrl_out(par_ctrl), .mask_lines_out(mask_lines), .trigger_out(trig));

  // a released bus shows the inverse so stale data cannot pass
  assign db_bus = db_oe ? db : ~db;
  initial forever #2 clk = ~clk;
  always @(posedge clk) ext_clk <= ~ext_clk;
  // done pulses and busy cycles, cleared by the scenarios that check them
  always @(posedge clk) begin
    if (!done_n) done_cnt++;
    if (busy) busy_cnt++;
  end

  task automatic reg_wr(input logic [ADDR_W-1:0] a,
                        input logic [REG_W-1:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic reg_rd(input logic [ADDR_W-1:0] a,
                        output logic [REG_W-1:0] d);
    @(posedge clk);
    req <= '{a, 32'h00000000, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    d = rdat;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk);
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    `CHK(busy, 1'b0)
  endtask

  // channels 1, 3, 4 from pins; pins and inputs change mid-run
  task automatic t_pins();
    ssaseq_samples_t exp_s;
    logic [DATA_W-1:0] d;
    logic oe;
    int order[3] = '{0, 2, 3};
    exp_s = smp;
    sel_src <= 1'b0;
    pins <= 4'b1101;
    done_cnt = 0;
    busy_cnt = 0;
    ssaseq_host_model_inst.fire(ACQ_CYCLES);
    pins <= 4'b0010;
    smp <= ~smp;
    wait_idle();
    `CHK(done_cnt, 3)
    `CHK(busy_cnt >= 3 * CONV_CYCLES, 1'b1)
    foreach (order[i]) begin
      ssaseq_host_model_inst.read_word(d, oe);
      `CHK(d, exp_s[order[i]])
      `CHK(oe, 1'b1)
    end
    `CHK(db_oe, 1'b0)
  endtask

  // mask picks channel 3 while pins point at channel 1
  task automatic t_mask();
    logic [DATA_W-1:0] d;
    logic oe;
    ssaseq_host_model_inst.write_mask(4'b0100);
    sel_src <= 1'b1;
    pins <= 4'b0001;
    reg_rd(REG_STATE, rdata);
    `CHK(rdata[3:0], 4'h4)
    done_cnt = 0;
    ssaseq_host_model_inst.fire(ACQ_CYCLES);
    wait_idle();
    `CHK(done_cnt, 1)
    ssaseq_host_model_inst.read_word(d, oe);
    `CHK(d, smp[2])
  endtask

  // sequence-done interrupt, refused retrigger, clear and enable masking
  task automatic t_irq();
    reg_wr(REG_IRQ_CLEAR, 32'h0000001F);
    reg_wr(REG_IRQ_ENABLE, 32'h00000001);
    reg_rd(REG_IRQ_ENABLE, rdata);
    `CHK(rdata, 32'h00000001)
    `CHK(irq, 1'b0)
    ssaseq_host_model_inst.fire(ACQ_CYCLES);
    ssaseq_host_model_inst.fire(ACQ_CYCLES);
    wait_idle();
    reg_rd(REG_STATUS, rdata);
    `CHK(rdata, 32'h00000007)
    `CHK(irq, 1'b1)
    reg_wr(REG_IRQ_CLEAR, 32'h00000001);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    reg_wr(REG_IRQ_ENABLE, 32'h00000002);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    reg_rd(REG_IRQ_CLEAR, rdata);
    `CHK(rdata, 32'h00000000)
    reg_rd(4'h6, rdata);
    `CHK(rdata, 32'h00000000)
  endtask

  // external timing runs far faster than the internal conversion; then an
  // early retrigger and a read inside the conversion set both reports
  task automatic t_ext();
    logic [DATA_W-1:0] d;
    logic oe;
    css <= 1'b1;
    reg_wr(REG_IRQ_CLEAR, 32'h0000001F);
    busy_cnt = 0;
    ssaseq_host_model_inst.fire(ACQ_CYCLES);
    wait_idle();
    `CHK(busy_cnt < CONV_CYCLES, 1'b1)
    ssaseq_host_model_inst.fire(0);
    repeat (4) @(posedge clk);
    ssaseq_host_model_inst.read_word(d, oe);
    `CHK(oe, 1'b1)
    wait_idle();
    reg_rd(REG_STATUS, rdata);
    `CHK(rdata, 32'h0000001B)
    css <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_pins();
    t_mask();
    t_irq();
    t_ext();
    tally_and_finish();
  end

  // whole run needs about 2600 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
`undef CHK
`default_nettype wire
